// ==== inc/tmz_pkg.sv ====
// Types shared by the timer modules
`default_nettype none
package tmz_pkg;
    typedef logic [7:0] tmz_byte_t;
    typedef logic [2:0] tmz_ratio_t;
    typedef enum logic [1:0] {
        TMZ_SRC_OFF = 2'b00,
        TMZ_SRC_INSTR = 2'b01,
        TMZ_SRC_EXT = 2'b10
    } tmz_src_e;
endpackage : tmz_pkg
`default_nettype wire

// ==== inc/tmz_presc_if.sv ====
// Control and output signals between the timer and the shared prescaler
`timescale 1ns/1ps
`default_nettype none
interface tmz_presc_if;
    import tmz_pkg::*;
    logic srcTick;
    logic clear;
    logic toWdt;
    tmz_ratio_t ratio;
    logic scaledTick;
    modport ctrl (output srcTick, output clear, output toWdt, output ratio, input scaledTick);
    modport unit (input srcTick, input clear, input toWdt, input ratio, output scaledTick);
endinterface : tmz_presc_if
`default_nettype wire

// ==== inc/tmz_regs.svh ====
// Register offsets, field positions and reset values of the shared-prescaler timer
`ifndef TMZ_REGS_SVH
`define TMZ_REGS_SVH
`define TMZ_ADDR_COUNT 8'h01
`define TMZ_ADDR_INTCTL 8'h0b
`define TMZ_ADDR_OPTION 8'h81
`define TMZ_ADDR_PORTADIR 8'h85
`define TMZ_ADDR_IRQSTAT 8'hf0
`define TMZ_ADDR_IRQMASK 8'hf1
`define TMZ_RST_COUNT 8'h00
`define TMZ_RST_INTCTL 8'h00
`define TMZ_RST_OPTION 8'hff
`define TMZ_RST_PORTADIR 8'h3f
`define TMZ_RST_IRQ 8'h00
`define TMZ_PORTADIR_MASK 8'h3f
`define TMZ_IRQ_MASK 8'h01
`define TMZ_IRQ_OVF_BIT 0
`define TMZ_INT_FLAG_BIT 2
`define TMZ_INT_EN_BIT 5
`define TMZ_OPT_SRC_BIT 5
`define TMZ_OPT_EDGE_BIT 4
`define TMZ_OPT_PSA_BIT 3
`define TMZ_OPT_RATIO_HI 2
`define TMZ_OPT_RATIO_LO 0
`define TMZ_COUNT_MAX 8'hff
`define TMZ_COUNT_ONE 8'h01
`define TMZ_INHIBIT_CYCLES 2'h2
`define TMZ_INHIBIT_NONE 2'h0
`define TMZ_INHIBIT_STEP 2'h1
`endif

// ==== src/tmz_prescaler.sv ====
// Shared 8-bit prescaler, serving either the timer or the watchdog
`timescale 1ns/1ps
`default_nettype none
module tmz_prescaler #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Link to the timer
    tmz_presc_if.unit pif
);
    import tmz_pkg::*;
    logic [W-1:0] presCount_r, presCount_nxt;
    logic scaled_r, scaled_nxt;
    logic [3:0] shiftBy;
    logic [W:0] mask;
    logic hit;

    always_comb begin
        // Watchdog ratios start at 1:1, timer ratios at 1:2
        shiftBy = pif.toWdt ? {1'b0, pif.ratio} : ({1'b0, pif.ratio} + 4'h1); // RL11 RL12 RL16
        mask = ((W + 1)'(1) << shiftBy) - (W + 1)'(1);
        hit = pif.srcTick && (({1'b0, presCount_r} & mask) == mask);
        presCount_nxt = presCount_r;
        if (pif.clear) begin
            presCount_nxt = '0; // RL13 RL14
        end else if (pif.srcTick) begin
            presCount_nxt = presCount_r + W'(1);
        end
        scaled_nxt = hit && !pif.clear;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            presCount_r <= '0;
            scaled_r <= 1'b0;
        end else begin
            presCount_r <= presCount_nxt;
            scaled_r <= scaled_nxt;
        end
    end

    assign pif.scaledTick = scaled_r;

    property p_clear_zero;
        @(posedge clock) disable iff (!rst_n)
        pif.clear |=> (presCount_r == '0);
    endproperty
    a_clear_zero: assert property (p_clear_zero) else $error("prescaler not cleared"); // RL13

    property p_ratio_hit;
        @(posedge clock) disable iff (!rst_n)
        (hit && !pif.clear) |=> scaled_r;
    endproperty
    a_ratio_hit: assert property (p_ratio_hit) else $error("scaled tick missing"); // RL11

    property p_tick_has_source;
        @(posedge clock) disable iff (!rst_n)
        scaled_r |-> $past(pif.srcTick);
    endproperty
    a_tick_has_source: assert property (p_tick_has_source) else $error("spurious scaled tick"); // RL16
endmodule : tmz_prescaler
`default_nettype wire

// ==== src/tmz_sync.sv ====
// Two-stage synchroniser and selectable edge detector for the external count pin
`timescale 1ns/1ps
`default_nettype none
module tmz_sync (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Pin and edge choice
    input wire logic pinIn,
    input wire logic fallingEdge,
    // Edge event
    output logic edgeTick
);
    logic meta_r, meta_nxt;
    logic sync_r, sync_nxt;
    logic prev_r, prev_nxt;
    logic edge_r, edge_nxt;

    always_comb begin
        meta_nxt = pinIn;
        sync_nxt = meta_r; // RL4
        prev_nxt = sync_r;
        edge_nxt = fallingEdge ? (prev_r & ~sync_r) : (~prev_r & sync_r); // RL3
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
            edge_r <= 1'b0;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
            prev_r <= prev_nxt;
            edge_r <= edge_nxt;
        end
    end

    assign edgeTick = edge_r;

    property p_edge_after_sync;
        @(posedge clock) disable iff (!rst_n)
        edge_r |-> ($past(sync_r) != $past(prev_r));
    endproperty
    a_edge_after_sync: assert property (p_edge_after_sync) else $error("edge without synced change"); // RL4
endmodule : tmz_sync
`default_nettype wire

// ==== src/tmz_timer.sv ====
// Eight-bit timer/counter with a prescaler shared with the watchdog
//
// Overview of operation
// RL1 - Timer mode without prescaler advances the count once per instruction cycle.
// RL2 - A software write to the count blocks counting for two instruction cycles.
// RL3 - Counter mode counts external pin edges; edge select picks rising or falling.
// RL4 - The external pin is synchronised before it can advance the count.
// RL5 - Passing from all ones to zero sets the overflow flag, bit 2.
// RL6 - Overflow request goes out only while enable bit 5 is set.
// RL7 - The overflow flag stays set until software clears it.
// RL8 - Sleep stops the timer so no overflow can happen.
// RL9 - One prescaler serves timer or watchdog; the other runs unscaled.
// RL10 - The prescaler count cannot be read or loaded by software.
// RL11 - Assigned to the timer, ratio bits choose 1:2 up to 1:256.
// RL12 - Assigned to the watchdog, ratio bits choose 1:1 up to 1:128.
// RL13 - With timer assignment, each count write zeroes the prescaler, keeps assignment.
// RL14 - With watchdog assignment, watchdog clear zeroes prescaler and watchdog count.
// RL15 - Software may reassign anytime, using a safe sequence toward the watchdog.
// RL16 - Ratio values are powers of two, doubling per step from value zero.
`timescale 1ns/1ps
`default_nettype none
`include "tmz_regs.svh"
module tmz_timer #(
    parameter int unsigned INSTR_DIV = 4
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Register port
    input wire tmz_pkg::tmz_byte_t regAddr,
    input wire tmz_pkg::tmz_byte_t regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output tmz_pkg::tmz_byte_t regRdData,
    // Core and watchdog status
    input wire logic sleepMode,
    input wire logic watchdogClearInstr,
    input wire logic watchdogRawTick,
    // External count pin
    input wire logic externalCountPin,
    // Outputs
    output logic overflowIrqReq,
    output logic irq,
    output logic watchdogTick,
    output logic watchdogCountClear,
    output tmz_pkg::tmz_byte_t portADirection
);
    import tmz_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [7:0] divCount_r, divCount_nxt;
    logic instrTick_r, instrTick_nxt;
    tmz_byte_t timerCount_r, timerCount_nxt;
    tmz_byte_t intCtl_r, intCtl_nxt;
    tmz_byte_t option_r, option_nxt;
    tmz_byte_t portADir_r, portADir_nxt;
    tmz_byte_t irqStatus_r, irqStatus_nxt;
    tmz_byte_t irqMask_r, irqMask_nxt;
    tmz_byte_t rdData_r, rdData_nxt;
    logic [1:0] inhibit_r, inhibit_nxt;
    logic ovfReq_r, ovfReq_nxt;
    logic irq_r, irq_nxt;
    logic wdtTick_r, wdtTick_nxt;
    logic wdtClr_r, wdtClr_nxt;
    logic wrCount, wrIntCtl, wrOption, wrPortADir, wrIrqMask, rdIrqStat;
    logic prescaler_assign, extEdge, srcEvent, incEvent, ovfSet;
    tmz_src_e srcMode;

    tmz_presc_if pif ();

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    tmz_sync u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .pinIn(externalCountPin),
        .fallingEdge(option_r[`TMZ_OPT_EDGE_BIT]),
        .edgeTick(extEdge)
    );

    tmz_prescaler #(.W(8)) u_presc (
        .clock(clock),
        .rst_n(rst_n),
        .pif(pif.unit)
    );

    // ------------------------------------------------------------
    // Instruction cycle divider
    // ------------------------------------------------------------
    always_comb begin
        instrTick_nxt = (divCount_r == 8'(INSTR_DIV - 1));
        divCount_nxt = instrTick_nxt ? 8'h00 : divCount_r + 8'h01;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            divCount_r <= 8'h00;
            instrTick_r <= 1'b0;
        end else begin
            divCount_r <= divCount_nxt;
            instrTick_r <= instrTick_nxt;
        end
    end

    // ------------------------------------------------------------
    // Counting path
    // ------------------------------------------------------------
    always_comb begin
        wrCount = regWrEn && (regAddr == `TMZ_ADDR_COUNT);
        prescaler_assign = option_r[`TMZ_OPT_PSA_BIT];
        if (sleepMode) begin
            srcMode = TMZ_SRC_OFF; // RL8
        end else if (option_r[`TMZ_OPT_SRC_BIT]) begin
            srcMode = TMZ_SRC_EXT; // RL3
        end else begin
            srcMode = TMZ_SRC_INSTR; // RL1
        end
        case (srcMode)
            TMZ_SRC_INSTR: srcEvent = instrTick_r;
            TMZ_SRC_EXT: srcEvent = extEdge;
            default: srcEvent = 1'b0;
        endcase
        // The prescaler goes to exactly one user; the other sees raw ticks
        pif.toWdt = prescaler_assign; // RL9
        pif.ratio = option_r[`TMZ_OPT_RATIO_HI:`TMZ_OPT_RATIO_LO]; // RL11 RL12
        pif.srcTick = prescaler_assign ? watchdogRawTick : srcEvent;
        pif.clear = prescaler_assign ? watchdogClearInstr : wrCount; // RL13 RL14
        // Sleep gates the delayed prescaler tick too
        incEvent = (prescaler_assign ? srcEvent : (pif.scaledTick && !sleepMode))
            && (inhibit_r == `TMZ_INHIBIT_NONE); // RL2 RL8
        ovfSet = incEvent && !wrCount && (timerCount_r == `TMZ_COUNT_MAX); // RL5
        wdtTick_nxt = prescaler_assign ? pif.scaledTick : watchdogRawTick; // RL9
        wdtClr_nxt = watchdogClearInstr; // RL14
    end

    // ------------------------------------------------------------
    // Registers and bus slave
    // ------------------------------------------------------------
    always_comb begin
        wrIntCtl = regWrEn && (regAddr == `TMZ_ADDR_INTCTL);
        wrOption = regWrEn && (regAddr == `TMZ_ADDR_OPTION);
        wrPortADir = regWrEn && (regAddr == `TMZ_ADDR_PORTADIR);
        wrIrqMask = regWrEn && (regAddr == `TMZ_ADDR_IRQMASK);
        rdIrqStat = regRdEn && (regAddr == `TMZ_ADDR_IRQSTAT);

        timerCount_nxt = timerCount_r;
        if (wrCount) begin
            timerCount_nxt = regWrData;
        end else if (incEvent) begin
            timerCount_nxt = timerCount_r + `TMZ_COUNT_ONE; // RL1 RL3
        end

        inhibit_nxt = inhibit_r;
        if (wrCount) begin
            inhibit_nxt = `TMZ_INHIBIT_CYCLES; // RL2
        end else if (instrTick_r && (inhibit_r != `TMZ_INHIBIT_NONE)) begin
            inhibit_nxt = inhibit_r - `TMZ_INHIBIT_STEP; // RL2
        end

        // A flag raised in the same cycle as a software clear stays set
        intCtl_nxt = wrIntCtl ? regWrData : intCtl_r; // RL7
        if (ovfSet) begin
            intCtl_nxt[`TMZ_INT_FLAG_BIT] = 1'b1; // RL5
        end

        option_nxt = wrOption ? regWrData : option_r;
        portADir_nxt = wrPortADir ? (regWrData & `TMZ_PORTADIR_MASK) : portADir_r;
        irqMask_nxt = wrIrqMask ? (regWrData & `TMZ_IRQ_MASK) : irqMask_r;

        irqStatus_nxt = rdIrqStat ? `TMZ_RST_IRQ : irqStatus_r;
        if (ovfSet) begin
            irqStatus_nxt[`TMZ_IRQ_OVF_BIT] = 1'b1;
        end

        ovfReq_nxt = intCtl_nxt[`TMZ_INT_FLAG_BIT] & intCtl_nxt[`TMZ_INT_EN_BIT]; // RL6
        irq_nxt = |(irqStatus_nxt & irqMask_nxt);

        // No address exposes the prescaler count
        rdData_nxt = 8'h00; // RL10
        if (regRdEn) begin
            case (regAddr)
                `TMZ_ADDR_COUNT: rdData_nxt = timerCount_r;
                `TMZ_ADDR_INTCTL: rdData_nxt = intCtl_r;
                `TMZ_ADDR_OPTION: rdData_nxt = option_r;
                `TMZ_ADDR_PORTADIR: rdData_nxt = portADir_r;
                `TMZ_ADDR_IRQSTAT: rdData_nxt = irqStatus_r;
                `TMZ_ADDR_IRQMASK: rdData_nxt = irqMask_r;
                default: rdData_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            timerCount_r <= `TMZ_RST_COUNT;
            inhibit_r <= `TMZ_INHIBIT_NONE;
            intCtl_r <= `TMZ_RST_INTCTL;
            option_r <= `TMZ_RST_OPTION;
            portADir_r <= `TMZ_RST_PORTADIR;
            irqStatus_r <= `TMZ_RST_IRQ;
            irqMask_r <= `TMZ_RST_IRQ;
            rdData_r <= 8'h00;
            ovfReq_r <= 1'b0;
            irq_r <= 1'b0;
            wdtTick_r <= 1'b0;
            wdtClr_r <= 1'b0;
        end else begin
            timerCount_r <= timerCount_nxt;
            inhibit_r <= inhibit_nxt;
            intCtl_r <= intCtl_nxt;
            option_r <= option_nxt;
            portADir_r <= portADir_nxt;
            irqStatus_r <= irqStatus_nxt;
            irqMask_r <= irqMask_nxt;
            rdData_r <= rdData_nxt;
            ovfReq_r <= ovfReq_nxt;
            irq_r <= irq_nxt;
            wdtTick_r <= wdtTick_nxt;
            wdtClr_r <= wdtClr_nxt;
        end
    end

    assign regRdData = rdData_r;
    assign overflowIrqReq = ovfReq_r;
    assign irq = irq_r;
    assign watchdogTick = wdtTick_r;
    assign watchdogCountClear = wdtClr_r;
    assign portADirection = portADir_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    property p_instr_count;
        (instrTick_r && !option_r[`TMZ_OPT_SRC_BIT] && prescaler_assign && !sleepMode && !wrCount
            && (inhibit_r == `TMZ_INHIBIT_NONE))
        |=> (timerCount_r == $past(timerCount_r) + 8'h01);
    endproperty
    a_instr_count: assert property (p_instr_count) else $error("timer missed a cycle"); // RL1

    property p_write_load;
        wrCount |=> (timerCount_r == $past(regWrData)) && (inhibit_r == `TMZ_INHIBIT_CYCLES);
    endproperty
    a_write_load: assert property (p_write_load) else $error("write not loaded"); // RL2

    property p_inhibit_hold;
        ((inhibit_r != `TMZ_INHIBIT_NONE) && !wrCount) |=> $stable(timerCount_r);
    endproperty
    a_inhibit_hold: assert property (p_inhibit_hold) else $error("count moved while inhibited"); // RL2

    property p_ext_count;
        (extEdge && option_r[`TMZ_OPT_SRC_BIT] && prescaler_assign && !sleepMode && !wrCount
            && (inhibit_r == `TMZ_INHIBIT_NONE))
        |=> (timerCount_r == $past(timerCount_r) + 8'h01);
    endproperty
    a_ext_count: assert property (p_ext_count) else $error("edge not counted"); // RL3

    property p_overflow_flag;
        (incEvent && !wrCount && (timerCount_r == `TMZ_COUNT_MAX))
        |=> ((timerCount_r == '0) && intCtl_r[`TMZ_INT_FLAG_BIT]);
    endproperty
    a_overflow_flag: assert property (p_overflow_flag) else $error("overflow flag not set"); // RL5

    property p_irq_gate;
        ovfReq_r == (intCtl_r[`TMZ_INT_FLAG_BIT] && intCtl_r[`TMZ_INT_EN_BIT]);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("overflow request not gated"); // RL6

    property p_flag_sticky;
        (intCtl_r[`TMZ_INT_FLAG_BIT] && !wrIntCtl) |=> intCtl_r[`TMZ_INT_FLAG_BIT];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped by itself"); // RL7

    property p_sleep_stop;
        (sleepMode && !wrCount) |=> $stable(timerCount_r) && !$rose(irqStatus_r[`TMZ_IRQ_OVF_BIT]);
    endproperty
    a_sleep_stop: assert property (p_sleep_stop) else $error("timer ran in sleep"); // RL8

    property p_wdt_unscaled;
        (!prescaler_assign && watchdogRawTick) |=> watchdogTick;
    endproperty
    a_wdt_unscaled: assert property (p_wdt_unscaled) else $error("watchdog tick lost"); // RL9

    property p_wdt_clear;
        watchdogClearInstr |=> watchdogCountClear;
    endproperty
    a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog clear not passed"); // RL14

    property p_wr_presc;
        (wrCount && !prescaler_assign) |-> pif.clear;
    endproperty
    a_wr_presc: assert property (p_wr_presc) else $error("prescaler kept on write"); // RL13

    property p_wr_assign;
        wrCount |=> $stable(prescaler_assign);
    endproperty
    a_wr_assign: assert property (p_wr_assign) else $error("assignment moved"); // RL13

    property p_clr_presc;
        (watchdogClearInstr && prescaler_assign) |-> pif.clear;
    endproperty
    a_clr_presc: assert property (p_clr_presc) else $error("prescaler kept on clear"); // RL14

    property p_wdt_source;
        prescaler_assign |-> (pif.srcTick == watchdogRawTick);
    endproperty
    a_wdt_source: assert property (p_wdt_source) else $error("prescaler on wrong source"); // RL9

    property p_sleep_idle;
        (sleepMode && !prescaler_assign) |-> !pif.srcTick;
    endproperty
    a_sleep_idle: assert property (p_sleep_idle) else $error("prescaler ran in sleep"); // RL8

    property p_ovf_status;
        ovfSet |=> irqStatus_r[`TMZ_IRQ_OVF_BIT];
    endproperty
    a_ovf_status: assert property (p_ovf_status) else $error("status not set"); // RL5

    property p_flag_source;
        $rose(intCtl_r[`TMZ_INT_FLAG_BIT])
        |-> ($past(ovfSet) || $past(wrIntCtl && regWrData[`TMZ_INT_FLAG_BIT]));
    endproperty
    a_flag_source: assert property (p_flag_source) else $error("flag set by itself"); // RL5

    property p_ovf_request;
        (ovfSet && intCtl_r[`TMZ_INT_EN_BIT] && !wrIntCtl) |=> overflowIrqReq;
    endproperty
    a_ovf_request: assert property (p_ovf_request) else $error("request not raised"); // RL6

    property p_unmapped_rd;
        (regRdEn && !(regAddr inside {`TMZ_ADDR_COUNT, `TMZ_ADDR_INTCTL, `TMZ_ADDR_OPTION,
            `TMZ_ADDR_PORTADIR, `TMZ_ADDR_IRQSTAT, `TMZ_ADDR_IRQMASK})) |=> (regRdData == '0);
    endproperty
    a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not zero"); // RL10

    c_overflow: cover property (ovfSet ##1 overflowIrqReq);
    c_inhibit: cover property (wrCount ##[1:20] incEvent);
    c_ext_edge: cover property (option_r[`TMZ_OPT_SRC_BIT] && extEdge && incEvent);
    c_wdt_scaled: cover property (prescaler_assign && pif.scaledTick ##1 watchdogTick);
endmodule : tmz_timer
`default_nettype wire

// ==== verif/tb_top.sv ====
// Self-checking bench for the shared-prescaler timer
`timescale 1ns/1ps
`default_nettype none
`include "tmz_regs.svh"
module tb_top;
    import tmz_pkg::*;
    localparam int RAW = 3;
    localparam int LIMIT = 60000;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    tmz_byte_t regAddr = 8'h00;
    tmz_byte_t regWrData = 8'h00;
    logic regWrEn = 1'b0;
    logic regRdEn = 1'b0;
    tmz_byte_t regRdData;
    logic sleepMode = 1'b0;
    logic wdClr = 1'b0;
    logic rawTick;
    logic pinReq = 1'b0;
    logic extPin;
    logic ovfReq;
    logic irq;
    logic wdTick;
    logic wdCntClr;
    tmz_byte_t portDir;
    int failures = 0;
    int checked = 0;
    int wdTicks = 0;
    int w0;
    tmz_byte_t a;
    tmz_byte_t b;

    always #2.5 clock = ~clock;
    // Counted on the falling edge, away from the design's updates
    always @(negedge clock) if (wdTick === 1'b1) wdTicks++;

    tmz_timer #(.INSTR_DIV(2)) uut (
        .clock(clock), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
        .sleepMode(sleepMode), .watchdogClearInstr(wdClr), .watchdogRawTick(rawTick),
        .externalCountPin(extPin), .overflowIrqReq(ovfReq), .irq(irq),
        .watchdogTick(wdTick), .watchdogCountClear(wdCntClr), .portADirection(portDir)
    );
    tmz_core_model #(.RAW_DIV(RAW)) partner (
        .clock(clock), .rst_n(rst_n), .pinReq(pinReq),
        .externalCountPin(extPin), .watchdogRawTick(rawTick)
    );

    // ------------------------------------------------------------
    // Bus access and comparison
    // ------------------------------------------------------------
    task automatic chk(input tmz_byte_t got, input tmz_byte_t lo, input tmz_byte_t hi);
        checked++;
        if ((^got === 1'bx) || got < lo || got > hi) begin
            failures++;
            $display("FAIL %0t got %h want %h..%h", $time, got, lo, hi);
        end
    endtask : chk

    task automatic wr(input tmz_byte_t ad, input tmz_byte_t d);
        regAddr <= ad;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge clock);
        regWrEn <= 1'b0;
        @(posedge clock);
    endtask : wr

    task automatic rd(input tmz_byte_t ad, output tmz_byte_t d);
        regAddr <= ad;
        regRdEn <= 1'b1;
        @(posedge clock);
        regRdEn <= 1'b0;
        @(posedge clock);
        d = regRdData;
    endtask : rd

    task automatic ex(input tmz_byte_t ad, input tmz_byte_t lo, input tmz_byte_t hi);
        tmz_byte_t d;
        rd(ad, d);
        chk(d, lo, hi);
    endtask : ex

    task automatic pulseClr();
        wdClr <= 1'b1;
        @(posedge clock);
        wdClr <= 1'b0;
        @(negedge clock);
        chk({7'h00, wdCntClr}, 8'h01, 8'h01);
        @(posedge clock);
    endtask : pulseClr

    task automatic give_verdict();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict

    initial begin
        repeat (LIMIT) @(posedge clock);
        failures++;
        $display("FAIL %0t watchdog expired", $time);
        give_verdict();
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        ex(`TMZ_ADDR_COUNT, 8'h00, 8'h00);
        ex(`TMZ_ADDR_INTCTL, 8'h00, 8'h00);
        ex(`TMZ_ADDR_OPTION, 8'hff, 8'hff);
        ex(`TMZ_ADDR_PORTADIR, 8'h3f, 8'h3f);
        ex(`TMZ_ADDR_IRQSTAT, 8'h00, 8'h00);
        ex(`TMZ_ADDR_IRQMASK, 8'h00, 8'h00);
        ex(8'h40, 8'h00, 8'h00);
        wr(`TMZ_ADDR_PORTADIR, 8'hff);
        ex(`TMZ_ADDR_PORTADIR, 8'h3f, 8'h3f);
        chk(portDir, 8'h3f, 8'h3f);
        // Unscaled timer mode: one step per instruction cycle of two clocks
        wr(`TMZ_ADDR_OPTION, 8'h08);
        rd(`TMZ_ADDR_COUNT, a);
        repeat (38) @(posedge clock);
        rd(`TMZ_ADDR_COUNT, b);
        chk(b - a, 8'h14, 8'h14);
        wr(`TMZ_ADDR_COUNT, 8'h40);
        repeat (18) @(posedge clock);
        ex(`TMZ_ADDR_COUNT, 8'h46, 8'h48);
        // Every timer ratio, four increments over four periods
        for (int r = 0; r < 8; r++) begin
            wr(`TMZ_ADDR_OPTION, 8'(r));
            repeat (4 << r) @(posedge clock);
            rd(`TMZ_ADDR_COUNT, a);
            repeat ((16 << r) - 2) @(posedge clock);
            rd(`TMZ_ADDR_COUNT, b);
            chk(b - a, 8'h04, 8'h04);
        end
        // Timer keeps the prescaler, watchdog runs unscaled
        w0 = wdTicks;
        repeat (RAW * 8) @(posedge clock);
        chk(8'(wdTicks - w0), 8'h08, 8'h08);
        // Repeated count writes keep a slow prescaler from ever reaching its end
        for (int i = 0; i < 4; i++) begin
            wr(`TMZ_ADDR_COUNT, 8'h33);
            repeat (300) @(posedge clock);
        end
        ex(`TMZ_ADDR_COUNT, 8'h33, 8'h33);
        ex(`TMZ_ADDR_OPTION, 8'h07, 8'h07);
        // Watchdog ratios
        pulseClr();
        for (int r = 0; r < 8; r++) begin
            wr(`TMZ_ADDR_OPTION, 8'h08 | 8'(r));
            repeat (RAW << r) @(posedge clock);
            w0 = wdTicks;
            repeat ((RAW * 8) << r) @(posedge clock);
            chk(8'(wdTicks - w0), 8'h08, 8'h08);
        end
        for (int i = 0; i < 4; i++) begin
            pulseClr();
            if (i == 0) w0 = wdTicks;
            repeat (200) @(posedge clock);
        end
        chk(8'(wdTicks - w0), 8'h00, 8'h00);
        // Sleep, then overflow and interrupt handling
        wr(`TMZ_ADDR_OPTION, 8'h08);
        sleepMode <= 1'b1;
        ex(`TMZ_ADDR_IRQSTAT, 8'h01, 8'h01);
        wr(`TMZ_ADDR_IRQMASK, 8'h01);
        wr(`TMZ_ADDR_INTCTL, 8'h20);
        wr(`TMZ_ADDR_COUNT, 8'hfe);
        repeat (40) @(posedge clock);
        ex(`TMZ_ADDR_COUNT, 8'hfe, 8'hfe);
        ex(`TMZ_ADDR_INTCTL, 8'h20, 8'h20);
        chk({7'h00, irq}, 8'h00, 8'h00);
        sleepMode <= 1'b0;
        repeat (20) @(posedge clock);
        @(negedge clock);
        chk({7'h00, ovfReq}, 8'h01, 8'h01);
        chk({7'h00, irq}, 8'h01, 8'h01);
        @(posedge clock);
        ex(`TMZ_ADDR_INTCTL, 8'h24, 8'h24);
        ex(`TMZ_ADDR_IRQSTAT, 8'h01, 8'h01);
        ex(`TMZ_ADDR_IRQSTAT, 8'h00, 8'h00);
        ex(`TMZ_ADDR_INTCTL, 8'h24, 8'h24);
        wr(`TMZ_ADDR_INTCTL, 8'h04);
        @(negedge clock);
        chk({7'h00, ovfReq}, 8'h00, 8'h00);
        chk({7'h00, irq}, 8'h00, 8'h00);
        @(posedge clock);
        wr(`TMZ_ADDR_INTCTL, 8'h00);
        ex(`TMZ_ADDR_INTCTL, 8'h00, 8'h00);
        wr(`TMZ_ADDR_IRQMASK, 8'h00);
        repeat (520) @(posedge clock);
        @(negedge clock);
        chk({7'h00, irq}, 8'h00, 8'h00);
        @(posedge clock);
        ex(`TMZ_ADDR_IRQSTAT, 8'h01, 8'h01);
        ex(`TMZ_ADDR_INTCTL, 8'h04, 8'h04);
        // Counter mode, rising then falling edges of the pin
        wr(`TMZ_ADDR_OPTION, 8'h28);
        rd(`TMZ_ADDR_COUNT, a);
        pinReq <= 1'b1;
        rd(`TMZ_ADDR_COUNT, b);
        chk(b, a, a);
        repeat (8) @(posedge clock);
        ex(`TMZ_ADDR_COUNT, a + 8'h01, a + 8'h01);
        pinReq <= 1'b0;
        repeat (10) @(posedge clock);
        ex(`TMZ_ADDR_COUNT, a + 8'h01, a + 8'h01);
        wr(`TMZ_ADDR_OPTION, 8'h38);
        pinReq <= 1'b1;
        repeat (10) @(posedge clock);
        ex(`TMZ_ADDR_COUNT, a + 8'h01, a + 8'h01);
        pinReq <= 1'b0;
        repeat (10) @(posedge clock);
        ex(`TMZ_ADDR_COUNT, a + 8'h02, a + 8'h02);
        // Counter mode through the prescaler: two rising edges per step
        wr(`TMZ_ADDR_OPTION, 8'h20);
        wr(`TMZ_ADDR_COUNT, 8'h10);
        repeat (6) @(posedge clock);
        for (int i = 0; i < 2; i++) begin
            pinReq <= 1'b1;
            repeat (8) @(posedge clock);
            ex(`TMZ_ADDR_COUNT, 8'h10 + 8'(i), 8'h10 + 8'(i));
            pinReq <= 1'b0;
            repeat (8) @(posedge clock);
        end
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire

// ==== verif/tmz_core_model.sv ====
// Behavioural far side of the timer: watchdog time base and external count pin source
`timescale 1ns/1ps
`default_nettype none
module tmz_core_model #(
    parameter int RAW_DIV = 3
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Pin level asked for by the bench
    input wire logic pinReq,
    // Towards the timer
    output logic externalCountPin,
    output logic watchdogRawTick
);
    int rawCnt_r;

    // Pin moves off the clock grid, as a free-running outside source would
    initial externalCountPin = 1'b0;
    always @(pinReq) begin
        externalCountPin <= #1.3 pinReq;
    end

    always_ff @(posedge clock) begin
        if (!rst_n || rawCnt_r == RAW_DIV - 1) begin
            rawCnt_r <= 0;
        end else begin
            rawCnt_r <= rawCnt_r + 1;
        end
    end
    assign watchdogRawTick = rst_n && (rawCnt_r == RAW_DIV - 1);
endmodule : tmz_core_model
`default_nettype wire
